/* core/biss_reader.sv */
`timescale 1ns/1ns
`include "biss_consts.svh"
// What this block does
// - single-turn bit count comes from option bits 0 to 5.
// - multi-turn bit count comes from option bits 8 to 12.
// - option bit 15 wraps position at the programmed counts per rev.
// - option bit 16 selects the mode C frame with its header bits.
// - sample per current-loop tick, or per servo tick when bit 17 set.
// - bit 19 turns an encoder error into a warning, not a fault.
// - bit 20 makes error and warning bits active low.
// - bit 21 places status before position, else after it.
// - bit 22 makes error the earlier status bit, else warning is.
// - bit 23 moves status bits right after the alignment bits.
// - bits 24 to 27 count alignment bits, which are discarded.
// - port-select bit 28 or 29 picks multi-mode port, else the primary port.
// - bit 30 gives a 2.5 MHz link clock, else 5 MHz.
// - frame splits into position, two status bits, alignment bits.
module biss_reader
  import biss_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cur_tick,
  input wire logic servo_tick,
  output logic ma_pri,
  output logic ma_mm,
  input wire logic slo_pri,
  input wire logic slo_mm,
  output logic irq,
  output logic pos_valid,
  output logic enc_fault,
  output logic enc_warn
);

  localparam int HALF_FAST_CYC =
    (`HALF_FAST_NS / `CLK_NS) > 0 ? (`HALF_FAST_NS / `CLK_NS) : 1;
  localparam int HALF_SLOW_CYC =
    (`HALF_SLOW_NS / `CLK_NS) > 0 ? (`HALF_SLOW_NS / `CLK_NS) : 1;

  function automatic logic [6:0] frame_len(input logic [31:0] o);
    frame_len = 7'(o[`OPT_AL_HI:`OPT_AL_LO]) + 7'(o[`OPT_MT_HI:`OPT_MT_LO])
      + 7'(o[`OPT_ST_HI:`OPT_ST_LO]) + `STAT_BITS
      + (o[`OPT_MODEC] ? `MODEC_HDR : 7'h00);
  endfunction

  function automatic logic [63:0] low_mask(input logic [6:0] w);
    low_mask = (64'h1 << w) - 64'h1;
  endfunction

  logic [31:0] opt_q, cpr_q, cfg_q;
  logic en_q;
  logic [`IRQ_W-1:0] istat_q, imask_q, ev;
  logic [31:0] pos_st_q, pos_mt_q;
  logic err_q, warn_q, valid_q;
  logic slo_pri_s1, slo_pri_s2, slo_mm_s1, slo_mm_s2;
  fsm_t st_q;
  logic [3:0] cnt_q;
  logic [6:0] bits_q, len_q;
  logic [127:0] sh_q;
  logic [3:0] half;
  logic [2:0] smp_q;
  logic trig, start, rise, sl, ma_act, port_mm;
  logic wr, rd_setup;

  // apb slave: zero wait, read data captured in setup
  assign wr = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        `A_OPT, `A_CPR, `A_CTRL, `A_ISTAT, `A_IMASK, `A_POS_ST,
        `A_POS_MT, `A_LSTAT: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (ce && rd_setup) begin
      case (paddr)
        `A_OPT: prdata <= opt_q;
        `A_CPR: prdata <= cpr_q;
        `A_CTRL: prdata <= {31'h00000000, en_q};
        `A_ISTAT: prdata <= {29'h00000000, istat_q};
        `A_IMASK: prdata <= {29'h00000000, imask_q};
        `A_POS_ST: prdata <= pos_st_q;
        `A_POS_MT: prdata <= pos_mt_q;
        `A_LSTAT: prdata <= {29'h00000000, st_q != S_IDLE, warn_q, err_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opt_q <= `OPT_RST;
      cpr_q <= `CPR_RST;
      en_q <= `CTRL_RST;
      imask_q <= `IRQ_RST;
    end else if (wr) begin
      case (paddr)
        `A_OPT: opt_q <= pwdata;
        `A_CPR: cpr_q <= pwdata;
        `A_CTRL: en_q <= pwdata[0];
        `A_IMASK: imask_q <= pwdata[`IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      istat_q <= `IRQ_RST;
    end else if (ce) begin
      if (wr && paddr == `A_ISTAT) begin
        istat_q <= (istat_q & ~pwdata[`IRQ_W-1:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
    end
  end

  assign irq = |(istat_q & imask_q);

  // slo lines come from the encoder, so two flops first
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slo_pri_s1 <= 1'b1;
      slo_pri_s2 <= 1'b1;
      slo_mm_s1 <= 1'b1;
      slo_mm_s2 <= 1'b1;
    end else if (ce) begin
      slo_pri_s1 <= slo_pri;
      slo_pri_s2 <= slo_pri_s1;
      slo_mm_s1 <= slo_mm;
      slo_mm_s2 <= slo_mm_s1;
    end
  end

  // config is frozen per frame so writes mid-frame cannot tear it
  assign port_mm = cfg_q[`OPT_PORT_A] | cfg_q[`OPT_PORT_B];
  assign sl = port_mm ? slo_mm_s2 : slo_pri_s2;
  assign half = cfg_q[`OPT_SLOW] ? 4'(HALF_SLOW_CYC)
                                 : 4'(HALF_FAST_CYC);
  assign trig = opt_q[`OPT_SERVO] ? servo_tick : cur_tick;
  assign start = (st_q == S_IDLE) & en_q & trig;
  assign rise = (st_q == S_LOW) & (cnt_q == 4'h0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      bits_q <= 7'h00;
      len_q <= 7'h00;
      cfg_q <= `OPT_RST;
    end else if (ce) begin
      case (st_q)
        S_IDLE: begin
          if (start) begin
            st_q <= S_LOW;
            cfg_q <= opt_q;
            len_q <= frame_len(opt_q);
            bits_q <= 7'h00;
            cnt_q <= (opt_q[`OPT_SLOW] ? 4'(HALF_SLOW_CYC)
                                       : 4'(HALF_FAST_CYC)) - 4'h1;
          end
        end
        S_LOW: begin
          if (cnt_q == 4'h0) begin
            st_q <= S_HIGH;
            bits_q <= bits_q + 7'h01;
            cnt_q <= half - 4'h1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_HIGH: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (bits_q == len_q) begin
            // last bit settles through the synchroniser, clock stays high
            st_q <= S_TAIL;
            cnt_q <= 4'((half << 1) - 4'h1);
          end else begin
            st_q <= S_LOW;
            cnt_q <= half - 4'h1;
          end
        end
        S_TAIL: begin
          if (cnt_q == 4'h0) begin
            st_q <= S_DONE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_DONE: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // idle link clock is high; the unused port stays idle
  assign ma_act = (st_q != S_LOW);
  assign ma_pri = port_mm ? 1'b1 : ma_act;
  assign ma_mm = port_mm ? ma_act : 1'b1;

  // bit taken three cycles after its rise: encoder turn plus two sync flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 128'h0;
      smp_q <= 3'h0;
    end else if (ce) begin
      smp_q <= {smp_q[1:0], rise};
      if (start) begin
        sh_q <= 128'h0;
      end else if (smp_q[2]) begin
        sh_q <= {sh_q[126:0], sl};
      end
    end
  end

  // field extraction; alignment and mode c header bits fall away
  logic [6:0] al_w, mt_w, st_w, pw, p_off, s_off;
  logic [127:0] p_sh, s_sh;
  logic [63:0] st_raw, mt_raw;
  logic [1:0] sbits;
  logic e_bit, w_bit;
  logic [31:0] st_wrapped;

  always_comb begin
    al_w = 7'(cfg_q[`OPT_AL_HI:`OPT_AL_LO]);
    mt_w = 7'(cfg_q[`OPT_MT_HI:`OPT_MT_LO]);
    st_w = 7'(cfg_q[`OPT_ST_HI:`OPT_ST_LO]);
    pw = mt_w + st_w;
    if (cfg_q[`OPT_STAT_FIRST]) begin
      p_off = 7'h00;
      s_off = pw;
    end else if (cfg_q[`OPT_ERR_AFTER_AL]) begin
      p_off = `STAT_BITS + al_w;
      s_off = 7'h00;
    end else begin
      p_off = `STAT_BITS;
      s_off = 7'h00;
    end
    p_sh = sh_q >> p_off;
    s_sh = sh_q >> s_off;
    st_raw = p_sh[63:0] & low_mask(st_w);
    mt_raw = (p_sh[127:64] == 64'h0 ? 64'h0 : 64'h0)
             | ((p_sh[63:0] >> st_w) & low_mask(mt_w));
    sbits = s_sh[1:0] ^ {2{cfg_q[`OPT_ACT_LOW]}};
    e_bit = cfg_q[`OPT_ERR_FIRST] ? sbits[1] : sbits[0];
    w_bit = cfg_q[`OPT_ERR_FIRST] ? sbits[0] : sbits[1];
    st_wrapped = st_raw[31:0];
    if (cfg_q[`OPT_WRAP] && cpr_q != 32'h00000000 &&
        st_raw[31:0] >= cpr_q) begin
      st_wrapped = st_raw[31:0] - cpr_q;
    end
  end

  always_comb begin
    ev = '0;
    if (st_q == S_DONE && ce) begin
      ev[`IRQ_DONE] = 1'b1;
      ev[`IRQ_FAULT] = e_bit & ~cfg_q[`OPT_ERR_WARN];
      ev[`IRQ_WARN] = w_bit | (e_bit & cfg_q[`OPT_ERR_WARN]);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos_st_q <= 32'h00000000;
      pos_mt_q <= 32'h00000000;
      err_q <= 1'b0;
      warn_q <= 1'b0;
      enc_fault <= 1'b0;
      enc_warn <= 1'b0;
      valid_q <= 1'b0;
    end else if (ce) begin
      valid_q <= (st_q == S_DONE);
      if (st_q == S_DONE) begin
        pos_st_q <= st_wrapped;
        pos_mt_q <= mt_raw[31:0];
        err_q <= e_bit;
        warn_q <= w_bit;
        enc_fault <= ev[`IRQ_FAULT];
        enc_warn <= ev[`IRQ_WARN];
      end
    end
  end

  assign pos_valid = valid_q;

  // checks
  property p_len;
    @(posedge mclk) disable iff (!arst_n)
      (ce && st_q == S_DONE) |-> bits_q == frame_len(cfg_q);
  endproperty
  a_len: assert property (p_len) else $error("period count off");

  property p_st_width;
    @(posedge mclk) disable iff (!arst_n)
      (valid_q && !cfg_q[`OPT_WRAP] && cfg_q[`OPT_ST_HI:`OPT_ST_LO] < 6'h20)
      |-> (pos_st_q >> cfg_q[`OPT_ST_HI:`OPT_ST_LO]) == 32'h0;
  endproperty
  a_st_width: assert property (p_st_width) else $error("st width");

  property p_mt_width;
    @(posedge mclk) disable iff (!arst_n)
      valid_q |-> (pos_mt_q >> cfg_q[`OPT_MT_HI:`OPT_MT_LO]) == 32'h0;
  endproperty
  a_mt_width: assert property (p_mt_width) else $error("mt width");

  property p_wrap;
    @(posedge mclk) disable iff (!arst_n)
      (valid_q && cfg_q[`OPT_WRAP] && cpr_q != 32'h0 && $stable(cpr_q))
      |-> pos_st_q < cpr_q || $past(st_raw[31:0]) >= (cpr_q << 1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_trig;
    @(posedge mclk) disable iff (!arst_n)
      (ce && $past(ce) && st_q == S_LOW && $past(st_q) == S_IDLE)
      |-> $past(opt_q[`OPT_SERVO] ? servo_tick : cur_tick);
  endproperty
  a_trig: assert property (p_trig) else $error("bad trigger");

  property p_fault;
    @(posedge mclk) disable iff (!arst_n)
      valid_q |-> enc_fault == (err_q & ~cfg_q[`OPT_ERR_WARN]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault wrong");

  property p_port;
    @(posedge mclk) disable iff (!arst_n)
      port_mm |-> ma_pri && ma_mm == ma_act;
  endproperty
  a_port: assert property (p_port) else $error("wrong port");

  sequence s_fast_low;
    ce && $fell(ma_act) && !cfg_q[`OPT_SLOW];
  endsequence
  sequence s_slow_low;
    ce && $fell(ma_act) && cfg_q[`OPT_SLOW];
  endsequence
  property p_rate;
    @(posedge mclk) disable iff (!arst_n)
      (s_fast_low |=> ma_act) and
      (s_slow_low ##1 ce |-> !ma_act ##1 ma_act);
  endproperty
  a_rate: assert property (p_rate) else $error("link rate");

endmodule

/* core/biss_consts.svh */
`ifndef BISS_CONSTS_SVH
`define BISS_CONSTS_SVH

// option word field positions
`define OPT_ST_LO 0
`define OPT_ST_HI 5
`define OPT_MT_LO 8
`define OPT_MT_HI 12
`define OPT_WRAP 15
`define OPT_MODEC 16
`define OPT_SERVO 17
`define OPT_ERR_WARN 19
`define OPT_ACT_LOW 20
`define OPT_STAT_FIRST 21
`define OPT_ERR_FIRST 22
`define OPT_ERR_AFTER_AL 23
`define OPT_AL_LO 24
`define OPT_AL_HI 27
`define OPT_PORT_A 28
`define OPT_PORT_B 29
`define OPT_SLOW 30

// register byte offsets
`define A_OPT 8'h00
`define A_CPR 8'h04
`define A_CTRL 8'h08
`define A_ISTAT 8'h0C
`define A_IMASK 8'h10
`define A_POS_ST 8'h14
`define A_POS_MT 8'h18
`define A_LSTAT 8'h1C

// reset values
`define OPT_RST 32'h00000000
`define CPR_RST 32'h00000000
`define CTRL_RST 1'h0
`define IRQ_RST 3'h0

// interrupt status bits
`define IRQ_W 3
`define IRQ_DONE 0
`define IRQ_FAULT 1
`define IRQ_WARN 2

// frame framing
`define STAT_BITS 7'h02
`define MODEC_HDR 7'h02

// timing: link half periods, system clock period
`define CLK_NS 100
`define HALF_FAST_NS 125
`define HALF_SLOW_NS 200

`endif

/* core/biss_pkg.sv */
package biss_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_LOW = 3'h1,
    S_HIGH = 3'h3,
    S_TAIL = 3'h2,
    S_DONE = 3'h6
  } fsm_t;
endpackage

/* verif/biss_enc_model.sv */
`timescale 1ns/1ns
module biss_enc_model (
  input wire logic ma,
  input wire logic arm,
  input wire logic [63:0] frame,
  input wire logic [6:0] len,
  output logic slo
);
  int idx = 0;
  initial slo = 1'h1;
  // a new frame flips the stale line so old data never looks valid
  always @(posedge arm) begin
    idx = 0;
    slo <= ~slo;
  end
  // data moves just after each rise, earliest bit is the msb
  always @(posedge ma) begin
    if (idx < len)
      slo <= frame[len - 1 - idx];
    else
      slo <= ~slo;
    idx = idx + 1;
  end
endmodule

/* verif/biss_reader_tb.sv */
`timescale 1ns/1ns
`include "biss_consts.svh"
module biss_reader_tb;
  import biss_pkg::*;
  typedef struct {int n; int h; logic [1:0] fw;} note_t;
  logic mclk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, cur_tick = 1'h0, servo_tick = 1'h0;
  logic port_q = 1'h0, arm = 1'h0, ma_q = 1'h1, oth_q = 1'h1;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] frame_v = 64'h0;
  logic [6:0] len_v = 7'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ma_pri, ma_mm, slo, irq, pos_valid;
  logic enc_fault, enc_warn;
  int fails = 0, total_checks = 0, nf = 0, no = 0, lo = 0;
  int got = 0, cyc = 0;
  int seed = 32'hBD2FFBEB;
  note_t q[$];
  note_t nt;
  wire ma_s = port_q ? ma_mm : ma_pri;
  wire ma_o = port_q ? ma_pri : ma_mm;
  logic [31:0] tbl [8] = '{32'h0, 32'h40008000, 32'h30000, 32'h180000,
    32'h600000, 32'h10800000, 32'h20900000, 32'h40420000};

  always #50 mclk = ~mclk;

  // the unused port gets inverted data, so a wrong pick shows up
  biss_reader i_dut (.mclk(mclk), .arst_n(arst_n), .ce(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_tick(cur_tick), .servo_tick(servo_tick), .ma_pri(ma_pri),
    .ma_mm(ma_mm), .slo_pri(port_q ? ~slo : slo),
    .slo_mm(port_q ? slo : ~slo), .irq(irq), .pos_valid(pos_valid),
    .enc_fault(enc_fault), .enc_warn(enc_warn));
  biss_enc_model i_enc (.ma(ma_s), .arm(arm), .frame(frame_v),
    .len(len_v), .slo(slo));

  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d, x, input logic xe);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    if (!w) chk(prdata, x, "rdata");
    chk(32'(pslverr), 32'(xe), "slverr");
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic tick(input logic s);
    @(posedge mclk);
    cur_tick <= !s;
    servo_tick <= s;
    @(posedge mclk);
    cur_tick <= 1'h0;
    servo_tick <= 1'h0;
  endtask

  function automatic logic [63:0] cat(input logic [63:0] f, v,
    input int w);
    return (f << w) | (v & ((64'h1 << w) - 64'h1));
  endfunction

  task automatic run_frame(input logic [31:0] fl, input logic [1:0] es);
    logic [31:0] o, st, mt, cpr, est;
    logic [63:0] f, pv, aj, sb;
    logic [1:0] fw;
    int stw, mtw, al, pw, n, k;
    stw = 8 + {$random(seed)} % 9;
    mtw = {$random(seed)} % 9;
    al = {$random(seed)} % 4;
    pw = stw + mtw;
    st = $random(seed) & ((32'h1 << stw) - 32'h1);
    mt = $random(seed) & ((32'h1 << mtw) - 32'h1);
    aj = 64'($random(seed));
    cpr = 32'h1 << (stw - 1);
    est = (fl[15] && st >= cpr) ? st - cpr : st;
    o = fl | 32'(stw) | 32'(mtw << 8) | 32'(al << 24);
    pv = (64'(mt) << stw) | 64'(st);
    sb = 64'((fl[22] ? es : {es[0], es[1]}) ^ {2{fl[20]}});
    fw = {es[1] & !fl[19], es[0] | (es[1] & fl[19])};
    f = fl[16] ? 64'h1 : 64'h0;
    if (fl[21])
      f = cat(cat(cat(f, aj, al), sb, 2), pv, pw);
    else if (fl[23])
      f = cat(cat(cat(f, pv, pw), aj, al), sb, 2);
    else
      f = cat(cat(cat(f, aj, al), pv, pw), sb, 2);
    n = al + pw + 2 + (fl[16] ? 2 : 0);
    acc(1'h1, `A_OPT, o, 32'h0, 1'h0);
    acc(1'h1, `A_CPR, cpr, 32'h0, 1'h0);
    acc(1'h1, `A_IMASK, es[0] ? 32'h7 : 32'h0, 32'h0, 1'h0);
    port_q <= fl[28] | fl[29];
    frame_v <= f;
    len_v <= 7'(n);
    arm <= 1'h1;
    nf = 0;
    no = 0;
    lo = 0;
    tick(!fl[17]);
    arm <= 1'h0;
    repeat (4) @(posedge mclk);
    chk(nf, 32'h0, "early start");
    q.push_back('{n, fl[30] ? 2 : 1, fw});
    k = got;
    tick(fl[17]);
    for (int t = 0; t < 3000 && got == k; t++) @(posedge mclk);
    chk(32'(irq), 32'(es[0]), "irq set");
    acc(1'h0, `A_POS_ST, 32'h0, est, 1'h0);
    acc(1'h0, `A_POS_MT, 32'h0, mt, 1'h0);
    acc(1'h0, `A_ISTAT, 32'h0, {29'h0, fw[0], fw[1], 1'h1}, 1'h0);
    acc(1'h1, `A_ISTAT, 32'h7, 32'h0, 1'h0);
    acc(1'h0, `A_ISTAT, 32'h0, 32'h0, 1'h0);
    chk(32'(irq), 32'h0, "irq clear");
    $display("frame test done, option %h", o);
  endtask

  always @(posedge mclk) begin
    if (ma_q && !ma_s) nf++;
    if (!ma_s && nf == 1) lo++;
    if (oth_q && !ma_o) no++;
    ma_q = ma_s;
    oth_q = ma_o;
    if (pos_valid === 1'h1) begin
      if (q.size() == 0)
        chk(32'h0, 32'h1, "unexpected frame");
      else begin
        nt = q.pop_front();
        chk(nf, nt.n, "clock periods");
        chk(lo, nt.h, "half period");
        chk(no, 32'h0, "other port");
        chk(32'({enc_fault, enc_warn}), 32'(nt.fw), "status");
      end
      got++;
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'h1;
    acc(1'h0, `A_OPT, 32'h0, `OPT_RST, 1'h0);
    acc(1'h0, `A_CPR, 32'h0, `CPR_RST, 1'h0);
    acc(1'h0, `A_IMASK, 32'h0, 32'h0, 1'h0);
    acc(1'h1, `A_POS_ST, 32'hFFFFFFFF, 32'h0, 1'h0);
    acc(1'h0, `A_POS_ST, 32'h0, 32'h0, 1'h0);
    acc(1'h1, 8'h20, 32'h1, 32'h0, 1'h1);
    acc(1'h0, 8'h20, 32'h0, 32'h0, 1'h1);
    acc(1'h1, `A_CTRL, 32'h1, 32'h0, 1'h0);
    $display("register test done");
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < 4; j++)
        run_frame(tbl[i], 2'(j));
    wrap_up();
  end
endmodule
